// ---- hdl/uart_rx_defs.svh ----
// Constants for the serial receiver with break transmitter
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

`define PHASE_LAST 4'hf
`define PHASE_FIRST 4'h1
`define VOTE_A 4'h7
`define VOTE_B 4'h8
`define VOTE_C 4'h9
`define WORD_BITS_EIGHT 4'h8
`define WORD_BITS_NINE 4'h9
`define BREAK_ZERO_BITS 4'hd
`define RX_BUF_WORDS 5'h02
`define FIFO_DEPTH 16
`define FIFO_WIDTH 11
`define FE_POS 9
`define PE_POS 10
`define NINTH_POS 8

`endif

// ---- hdl/uart_rx_pkg.sv ----
// Types shared by the serial receiver and transmitter
package uart_rx_pkg;
  typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} tx_state_t;
endpackage

// ---- hdl/rx_word_fifo.sv ----
// Word FIFO with a registered head entry
`timescale 1ns/1ps
module rx_word_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // Clock and control
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] head_reg;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = head_reg;
  assign o_count = count_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_clk_en) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head register always holds the oldest entry
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      head_reg <= '0;
    end else if (i_clk_en) begin
      if (push && (count_reg == '0 || (count_reg == (AW+1)'(1) && pop))) begin
        head_reg <= i_in_data;
      end else if (pop && count_reg > (AW+1)'(1)) begin
        head_reg <= mem[rd_ptr_reg + 1'b1];
      end
    end
  end
endmodule // rx_word_fifo

// ---- hdl/uart_rx_break_tx.sv ----
// Serial receiver with oversampled recovery and break-capable transmitter
`timescale 1ns/1ps
`include "uart_rx_defs.svh"
module uart_rx_break_tx (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Configuration
  input wire logic i_rx_enable_bit,
  input wire logic i_word_length_select,
  input wire logic i_parity_enable_bit,
  input wire logic i_parity_type_bit,
  input wire logic i_stop_count_select,
  input wire logic [7:0] i_baud_divisor,
  input wire logic i_rx_interrupt_enable,
  input wire logic i_break_request_bit,
  // Software access strobes
  input wire logic i_status_access,
  input wire logic i_data_read,
  input wire logic i_tx_write,
  input wire logic [8:0] i_tx_data,
  // Serial pins
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  // Receive data
  output logic [7:0] o_serial_data_buffer,
  output logic o_rx_ninth_bit,
  // Status flags
  output logic o_rx_data_available_flag,
  output logic o_overrun_flag,
  output logic o_noise_flag,
  output logic o_framing_error_flag,
  output logic o_parity_error_flag,
  output logic o_rx_idle_flag,
  output logic o_tx_buffer_empty_flag,
  output logic o_tx_idle_flag,
  // Interrupt requests
  output logic o_rx_irq,
  output logic o_tx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? `WORD_BITS_NINE : `WORD_BITS_EIGHT;
  endfunction

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic parity_of(input logic [8:0] w, input logic [3:0] n);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) p = p ^ w[i];
    end
    parity_of = p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] pre_cnt_reg;
  logic tick;
  logic sync1_reg;
  logic sync2_reg;
  logic [3:0] nbits;
  uart_rx_pkg::rx_state_t rx_state_reg;
  logic [3:0] rx_phase_reg;
  logic [3:0] rx_idx_reg;
  logic [8:0] rx_shift_reg;
  logic [2:0] vote_reg;
  logic frame_noise_reg;
  logic frame_err_reg;
  logic rx_idle_reg;
  logic bit_done;
  logic bit_val;
  logic bit_noisy;
  logic frame_end;
  logic fe_now;
  logic pe_now;
  logic room;
  logic push;
  logic overrun_ev;
  logic fifo_ready;
  logic fifo_valid;
  logic [`FIFO_WIDTH-1:0] fifo_head;
  logic [4:0] fifo_count;
  logic [8:0] rx_word;
  logic status_seen_reg;
  logic rd_clear;
  logic pop;
  logic overrun_reg;
  logic noise_reg;
  logic rx_irq_reg;
  logic avail_reg;
  uart_rx_pkg::tx_state_t tx_state_reg;
  logic [3:0] tx_phase_reg;
  logic [3:0] tx_idx_reg;
  logic [8:0] tx_shift_reg;
  logic [8:0] hold_reg;
  logic hold_full_reg;
  logic brk_frame_reg;
  logic [8:0] brk_cnt_reg;
  logic break_armed_reg;
  logic tx_empty_reg;
  logic tx_idle_reg;
  logic tx_irq_reg;
  logic line_reg;
  logic tx_bit_done;
  logic wr_ok;
  logic load_data;
  logic start_break;
  logic tx_frame_done;
  logic [8:0] tx_frame;

  assign nbits = word_bits(i_word_length_select);

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock: sixteen ticks per bit

  assign tick = (pre_cnt_reg == i_baud_divisor);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pre_cnt_reg <= 8'h00;
    end else if (i_clk_en) begin
      pre_cnt_reg <= tick ? 8'h00 : 8'(pre_cnt_reg + 8'h01);
    end
  end

  // Pin synchroniser
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else if (i_clk_en) begin
      sync1_reg <= i_serial_in_pin;
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  assign bit_done = tick && (rx_phase_reg == `PHASE_LAST);
  assign bit_val = majority(vote_reg);
  assign bit_noisy = (vote_reg != 3'h0) && (vote_reg != 3'h7);
  assign frame_end = (rx_state_reg == uart_rx_pkg::RX_STOP) && bit_done &&
                     (!i_stop_count_select || rx_idx_reg != 4'h0);
  assign fe_now = frame_err_reg || !bit_val;
  assign pe_now = i_parity_enable_bit &&
                  (parity_of(rx_shift_reg, nbits) != i_parity_type_bit);
  assign room = fifo_ready && (fifo_count < `RX_BUF_WORDS);
  assign push = frame_end && room;
  assign overrun_ev = frame_end && !room;
  assign rx_word = i_word_length_select ? rx_shift_reg : {1'b0, rx_shift_reg[7:0]};

  // Three samples around the bit centre
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      vote_reg <= 3'h7;
    end else if (i_clk_en && tick) begin
      if (rx_phase_reg == `VOTE_A) vote_reg[0] <= sync2_reg;
      if (rx_phase_reg == `VOTE_B) vote_reg[1] <= sync2_reg;
      if (rx_phase_reg == `VOTE_C) vote_reg[2] <= sync2_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_state_reg <= uart_rx_pkg::RX_HUNT;
      rx_phase_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      frame_noise_reg <= 1'b0;
      frame_err_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_rx_enable_bit) begin
        rx_state_reg <= uart_rx_pkg::RX_HUNT;
        rx_phase_reg <= 4'h0;
      end else begin
        if (tick) rx_phase_reg <= rx_phase_reg + 4'h1;
        if (bit_done && bit_noisy) frame_noise_reg <= 1'b1;
        case (rx_state_reg)
          uart_rx_pkg::RX_HUNT: begin
            if (tick && !sync2_reg) begin
              rx_state_reg <= uart_rx_pkg::RX_START;
              rx_phase_reg <= `PHASE_FIRST;
              rx_shift_reg <= 9'h000;
              frame_noise_reg <= 1'b0;
              frame_err_reg <= 1'b0;
            end
          end
          uart_rx_pkg::RX_START: begin
            if (bit_done) begin
              rx_idx_reg <= 4'h0;
              rx_state_reg <= bit_val ? uart_rx_pkg::RX_HUNT : uart_rx_pkg::RX_DATA;
            end
          end
          uart_rx_pkg::RX_DATA: begin
            if (bit_done) begin
              rx_shift_reg[rx_idx_reg] <= bit_val;
              if (rx_idx_reg == nbits - 4'h1) begin
                rx_idx_reg <= 4'h0;
                rx_state_reg <= uart_rx_pkg::RX_STOP;
              end else begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
              end
            end
          end
          uart_rx_pkg::RX_STOP: begin
            if (bit_done) begin
              frame_err_reg <= fe_now;
              rx_idx_reg <= 4'h1;
              if (frame_end) begin
                rx_state_reg <= fe_now ? uart_rx_pkg::RX_WAIT_HIGH : uart_rx_pkg::RX_HUNT;
              end
            end
          end
          uart_rx_pkg::RX_WAIT_HIGH: begin
            if (tick && sync2_reg) rx_state_reg <= uart_rx_pkg::RX_HUNT;
          end
          default: rx_state_reg <= uart_rx_pkg::RX_HUNT;
        endcase
      end
    end
  end

  // Receiver idle status
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_idle_reg <= 1'b1;
    end else if (i_clk_en) begin
      if (!i_rx_enable_bit || frame_end) begin
        rx_idle_reg <= 1'b1;
      end else if (rx_state_reg == uart_rx_pkg::RX_HUNT && tick && !sync2_reg) begin
        rx_idle_reg <= 1'b0;
      end else if (rx_state_reg == uart_rx_pkg::RX_START && bit_done && bit_val) begin
        rx_idle_reg <= 1'b1;
      end
    end
  end

  // Receive buffer; error bits travel with their word
  rx_word_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_in_valid(push),
    .i_in_data({pe_now, fe_now, rx_word}),
    .o_in_ready(fifo_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_head),
    .i_out_ready(pop),
    .o_count(fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Software access sequence and receive flags

  assign rd_clear = i_data_read && status_seen_reg;
  assign pop = i_data_read && fifo_valid;
  assign wr_ok = i_tx_write && status_seen_reg && tx_empty_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      status_seen_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (i_status_access) status_seen_reg <= 1'b1;
      else if (i_data_read || i_tx_write) status_seen_reg <= 1'b0;
    end
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      overrun_reg <= 1'b0;
      noise_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (overrun_ev) overrun_reg <= 1'b1;
      else if (rd_clear) overrun_reg <= 1'b0;
      if (push && (frame_noise_reg || bit_noisy)) noise_reg <= 1'b1;
      else if (rd_clear) noise_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_irq_reg <= 1'b0;
    end else if (i_clk_en) begin
      rx_irq_reg <= i_rx_interrupt_enable && (push || overrun_ev);
    end
  end

  // Data available follows the buffer's next fill level
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) avail_reg <= 1'b0;
    else if (i_clk_en) avail_reg <= push || (fifo_count > 5'h01) || (fifo_valid && !pop);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  assign tx_bit_done = tick && (tx_phase_reg == `PHASE_LAST);
  assign start_break = (tx_state_reg == uart_rx_pkg::TX_IDLE) && break_armed_reg;
  assign load_data = (tx_state_reg == uart_rx_pkg::TX_IDLE) && !break_armed_reg &&
                     hold_full_reg;
  assign tx_frame_done = (tx_state_reg == uart_rx_pkg::TX_STOP) && tx_bit_done &&
                         (!i_stop_count_select || tx_idx_reg != 4'h0);

  always_comb begin
    tx_frame = hold_reg;
    if (i_parity_enable_bit) begin
      tx_frame[nbits - 4'h1] = parity_of(hold_reg, nbits - 4'h1) ^ i_parity_type_bit;
    end
  end

  // Holding register between software and shifter
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hold_reg <= 9'h000;
      hold_full_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ok) begin
        hold_reg <= i_tx_data;
        hold_full_reg <= 1'b1;
      end else if (load_data) begin
        hold_full_reg <= 1'b0;
      end
    end
  end

  // Break request must be held while idle before it arms
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      brk_cnt_reg <= 9'h000;
      break_armed_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_break_request_bit || !tx_idle_reg || start_break) begin
        brk_cnt_reg <= 9'h000;
      end else if (brk_cnt_reg <= {1'b0, i_baud_divisor} + 9'h001) begin
        brk_cnt_reg <= brk_cnt_reg + 9'h001;
      end
      if (start_break) begin
        break_armed_reg <= 1'b0;
      end else if (brk_cnt_reg > {1'b0, i_baud_divisor} + 9'h001) begin
        break_armed_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_state_reg <= uart_rx_pkg::TX_IDLE;
      tx_phase_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_shift_reg <= 9'h000;
      brk_frame_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (tick) tx_phase_reg <= tx_phase_reg + 4'h1;
      case (tx_state_reg)
        uart_rx_pkg::TX_IDLE: begin
          tx_phase_reg <= 4'h0;
          if (start_break || load_data) begin
            tx_state_reg <= uart_rx_pkg::TX_START;
            brk_frame_reg <= start_break;
            tx_shift_reg <= tx_frame;
          end
        end
        uart_rx_pkg::TX_START: begin
          if (tx_bit_done) begin
            tx_idx_reg <= 4'h0;
            tx_state_reg <= brk_frame_reg ? uart_rx_pkg::TX_BREAK : uart_rx_pkg::TX_DATA;
          end
        end
        uart_rx_pkg::TX_DATA: begin
          if (tx_bit_done) begin
            if (tx_idx_reg == nbits - 4'h1) begin
              tx_idx_reg <= 4'h0;
              tx_state_reg <= uart_rx_pkg::TX_STOP;
            end else begin
              tx_idx_reg <= tx_idx_reg + 4'h1;
            end
          end
        end
        uart_rx_pkg::TX_BREAK: begin
          if (tx_bit_done) begin
            if (tx_idx_reg == `BREAK_ZERO_BITS - 4'h1) begin
              tx_idx_reg <= 4'h0;
              tx_state_reg <= uart_rx_pkg::TX_STOP;
            end else begin
              tx_idx_reg <= tx_idx_reg + 4'h1;
            end
          end
        end
        uart_rx_pkg::TX_STOP: begin
          if (tx_frame_done) tx_state_reg <= uart_rx_pkg::TX_IDLE;
          else if (tx_bit_done) tx_idx_reg <= 4'h1;
        end
        default: tx_state_reg <= uart_rx_pkg::TX_IDLE;
      endcase
    end
  end

  // Line level follows the transmit state
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      line_reg <= 1'b1;
    end else if (i_clk_en) begin
      case (tx_state_reg)
        uart_rx_pkg::TX_START: line_reg <= 1'b0;
        uart_rx_pkg::TX_BREAK: line_reg <= 1'b0;
        uart_rx_pkg::TX_DATA: line_reg <= tx_shift_reg[tx_idx_reg];
        default: line_reg <= 1'b1;
      endcase
    end
  end

  // Transmit flags; hardware set wins over software clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_empty_reg <= 1'b1;
      tx_idle_reg <= 1'b1;
      tx_irq_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (load_data) tx_empty_reg <= 1'b1;
      else if (wr_ok) tx_empty_reg <= 1'b0;
      if (tx_frame_done) tx_idle_reg <= 1'b1;
      else if (wr_ok || start_break) tx_idle_reg <= 1'b0;
      tx_irq_reg <= load_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_serial_out_pin = line_reg;
  assign o_serial_data_buffer = fifo_head[7:0];
  assign o_rx_ninth_bit = fifo_head[`NINTH_POS];
  assign o_rx_data_available_flag = avail_reg;
  assign o_overrun_flag = overrun_reg;
  assign o_noise_flag = noise_reg;
  assign o_framing_error_flag = fifo_head[`FE_POS];
  assign o_parity_error_flag = fifo_head[`PE_POS];
  assign o_rx_idle_flag = rx_idle_reg;
  assign o_tx_buffer_empty_flag = tx_empty_reg;
  assign o_tx_idle_flag = tx_idle_reg;
  assign o_rx_irq = rx_irq_reg;
  assign o_tx_irq = tx_irq_reg;

endmodule // uart_rx_break_tx

// ---- sim/uart_rx_break_tx_props.sv ----
// Concurrent checks on the ports of the serial receiver with break transmitter
`timescale 1ns/1ps
module uart_rx_break_tx_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched inputs
  input wire logic i_rx_interrupt_enable,
  input wire logic i_break_request_bit,
  input wire logic i_status_access,
  input wire logic i_data_read,
  input wire logic i_tx_write,
  input wire logic i_serial_in_pin,
  // Watched outputs
  input wire logic o_serial_out_pin,
  input wire logic [7:0] o_serial_data_buffer,
  input wire logic o_rx_data_available_flag,
  input wire logic o_overrun_flag,
  input wire logic o_noise_flag,
  input wire logic o_framing_error_flag,
  input wire logic o_rx_idle_flag,
  input wire logic o_tx_buffer_empty_flag,
  input wire logic o_tx_idle_flag,
  input wire logic o_rx_irq,
  input wire logic o_tx_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  property p_irq_gate;
    o_rx_irq |-> $past(i_rx_interrupt_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("rx irq while disabled");
  property p_irq_push;
    $rose(o_rx_data_available_flag) && $past(i_rx_interrupt_enable) |-> o_rx_irq;
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("no irq on word");
  property p_noise;
    $rose(o_noise_flag) |-> o_rx_data_available_flag;
  endproperty
  a_noise: assert property (p_noise) else $error("noise without data");
  property p_overrun;
    $rose(o_overrun_flag) |-> o_rx_data_available_flag && (o_rx_irq == $past(i_rx_interrupt_enable));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun handling wrong");
  property p_clear;
    ($fell(o_overrun_flag) || $fell(o_noise_flag)) && !$past(i_rst) |-> $past(i_data_read);
  endproperty
  a_clear: assert property (p_clear) else $error("flag cleared without read");
  property p_head_kept;
    $past(o_rx_data_available_flag) && !$past(i_data_read) && !$past(i_rst)
      |-> $stable(o_serial_data_buffer);
  endproperty
  a_head_kept: assert property (p_head_kept) else $error("buffered word changed");
  property p_idle_start;
    $fell(o_rx_idle_flag) |-> !$past(i_serial_in_pin, 3);
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("idle fell without start");
  property p_tx_seq;
    i_status_access ##1 (i_tx_write && o_tx_buffer_empty_flag) |=> !o_tx_idle_flag;
  endproperty
  a_tx_seq: assert property (p_tx_seq) else $error("tx idle not cleared");
  property p_tx_irq;
    o_tx_irq |-> $past(!o_tx_buffer_empty_flag);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq without data");
  property p_break_wait;
    $rose(i_break_request_bit) && o_tx_idle_flag && o_tx_buffer_empty_flag
      |-> o_serial_out_pin [*2];
  endproperty
  a_break_wait: assert property (p_break_wait) else $error("break sent too early");
  property p_idle_line;
    o_tx_idle_flag && $past(o_tx_idle_flag) |-> o_serial_out_pin;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("line low while idle");
  c_overrun: cover property ($rose(o_overrun_flag));
  c_noise: cover property ($rose(o_noise_flag));
  c_break_rx: cover property ($rose(o_rx_data_available_flag) && o_framing_error_flag);
  c_tx_irq: cover property (o_tx_irq);
endmodule // uart_rx_break_tx_chk

bind uart_rx_break_tx uart_rx_break_tx_chk chk_i (.i_sys_clk, .i_rst, .i_rx_interrupt_enable,
  .i_break_request_bit, .i_status_access, .i_data_read, .i_tx_write, .i_serial_in_pin,
  .o_serial_out_pin, .o_serial_data_buffer, .o_rx_data_available_flag, .o_overrun_flag,
  .o_noise_flag, .o_framing_error_flag, .o_rx_idle_flag, .o_tx_buffer_empty_flag,
  .o_tx_idle_flag, .o_rx_irq, .o_tx_irq);

// ---- sim/uart_far_end.sv ----
// Remote serial transceiver model on the receive and transmit pins
`timescale 1ns/1ps
module uart_far_end (
  // Clock
  input wire logic i_sys_clk,
  // Serial lines
  output logic o_line,
  input wire logic i_tx_line,
  // Clocks of the last low stretch on the transmit line
  output int o_low_run
);
  int run;
  initial begin
    o_line = 1'b1;
    o_low_run = 0;
    run = 0;
  end
  // Sixteen clocks per bit, optional one-clock glitch mid-bit
  task automatic send_bits(input logic [23:0] pat, input int n, input int gl);
    for (int b = 0; b < n; b++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge i_sys_clk);
        o_line <= pat[b] ^ (b == gl && t == 8);
      end
    end
    @(posedge i_sys_clk);
    o_line <= 1'b1;
  endtask
  always @(posedge i_sys_clk) begin
    if (i_tx_line === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      o_low_run <= run;
      run <= 0;
    end
  end
endmodule // uart_far_end

// ---- sim/test_uart_rx_break_tx.sv ----
// Self-checking bench for the serial receiver with break transmitter
`timescale 1ns/1ps
module test_uart_rx_break_tx;
  logic i_sys_clk, i_rst = 1'b1, i_clk_en = 1'b1, i_rx_enable_bit = 1'b0;
  logic i_word_length_select = 1'b0, i_parity_enable_bit = 1'b0, i_parity_type_bit = 1'b0;
  logic i_stop_count_select = 1'b0, i_rx_interrupt_enable = 1'b0, i_break_request_bit = 1'b0;
  logic i_status_access = 1'b0, i_data_read = 1'b0, i_tx_write = 1'b0;
  logic [7:0] i_baud_divisor = 8'h00;
  logic [8:0] i_tx_data = 9'h000;
  wire i_serial_in_pin;
  logic o_serial_out_pin, o_rx_ninth_bit, o_rx_data_available_flag, o_overrun_flag;
  logic o_noise_flag, o_framing_error_flag, o_parity_error_flag, o_rx_idle_flag;
  logic o_tx_buffer_empty_flag, o_tx_idle_flag, o_rx_irq, o_tx_irq;
  logic [7:0] o_serial_data_buffer;
  logic [10:0] exp_q[$];
  int errors = 0, compares = 0, irq_cnt = 0, txirq_cnt = 0;

  uart_rx_break_tx dut (.i_sys_clk, .i_rst, .i_clk_en, .i_rx_enable_bit, .i_word_length_select,
    .i_parity_enable_bit, .i_parity_type_bit, .i_stop_count_select, .i_baud_divisor,
    .i_rx_interrupt_enable, .i_break_request_bit, .i_status_access, .i_data_read, .i_tx_write,
    .i_tx_data, .i_serial_in_pin, .o_serial_out_pin, .o_serial_data_buffer, .o_rx_ninth_bit,
    .o_rx_data_available_flag, .o_overrun_flag, .o_noise_flag, .o_framing_error_flag,
    .o_parity_error_flag, .o_rx_idle_flag, .o_tx_buffer_empty_flag, .o_tx_idle_flag,
    .o_rx_irq, .o_tx_irq);
  uart_far_end far (.i_sys_clk, .o_line(i_serial_in_pin), .i_tx_line(o_serial_out_pin),
    .o_low_run());
  ////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Status access, then a data read or a transmit write
  task automatic sw_seq(input logic wr);
    @(posedge i_sys_clk);
    i_status_access <= 1'b1;
    @(posedge i_sys_clk);
    i_status_access <= 1'b0;
    i_data_read <= !wr;
    i_tx_write <= wr;
    i_tx_data <= 9'h0f0;
    @(posedge i_sys_clk);
    i_data_read <= 1'b0;
    i_tx_write <= 1'b0;
  endtask
  task automatic rx_word(input logic [8:0] w, input int sb, input int gl, input logic bad);
    logic [23:0] pat;
    logic [8:0] v;
    int n;
    n = i_word_length_select ? 9 : 8;
    v = w & (i_word_length_select ? 9'h1ff : 9'h0ff);
    if (i_parity_enable_bit) begin
      v[n-1] = 1'b0;
      v[n-1] = ^v ^ i_parity_type_bit ^ bad;
    end
    pat = '1;
    pat[0] = 1'b0;
    for (int i = 0; i < n; i++) pat[i+1] = v[i];
    if (sb > 0) pat[n+sb] = 1'b0;
    exp_q.push_back({i_parity_enable_bit & bad, sb > 0, v});
    far.send_bits(pat, n + 3 + i_stop_count_select, gl);
  endtask
  task automatic wait_line(input logic v);
    for (int k = 0; k < 1000 && o_serial_out_pin !== v; k++) @(negedge i_sys_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    errors++;
    end_of_test();
  end
  // Results are compared when software pops a word, flags read with the data
  always @(posedge i_sys_clk) begin
    if (o_rx_irq === 1'b1) irq_cnt++;
    if (o_tx_irq === 1'b1) txirq_cnt++;
    if (i_data_read === 1'b1 && o_rx_data_available_flag === 1'b1) begin
      if (exp_q.size() == 0) chk(12'h000, 12'hfff);
      else chk({o_parity_error_flag, o_framing_error_flag, o_rx_ninth_bit,
        o_serial_data_buffer}, {1'b0, exp_q.pop_front()});
    end
  end
  initial begin
    void'($urandom(32'he31f2893));
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    chk({o_rx_data_available_flag, o_overrun_flag, o_noise_flag, o_framing_error_flag,
      o_parity_error_flag, o_rx_idle_flag, o_tx_buffer_empty_flag, o_tx_idle_flag,
      o_serial_out_pin}, 12'h00f);
    @(posedge i_sys_clk);
    i_rx_enable_bit <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_sys_clk);
      i_word_length_select <= i[0];
      i_parity_enable_bit <= i[1];
      i_parity_type_bit <= i[2];
      @(posedge i_sys_clk);
      rx_word(9'($urandom), 0, -1, i[0]);
      sw_seq(1'b0);
    end
    i_word_length_select <= 1'b0;
    i_parity_enable_bit <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge i_sys_clk);
      i_stop_count_select <= s[0];
      @(posedge i_sys_clk);
      rx_word(9'($urandom), s + 1, -1, 1'b0);
      sw_seq(1'b0);
    end
    i_stop_count_select <= 1'b0;
    fork
      rx_word(9'h0a5, 0, 4, 1'b0);
      begin
        repeat (80) @(negedge i_sys_clk);
        chk(o_rx_idle_flag, 12'h000);
      end
    join
    @(negedge i_sys_clk);
    chk({o_noise_flag, o_rx_idle_flag, 10'(irq_cnt)}, 12'hc00);
    sw_seq(1'b0);
    @(negedge i_sys_clk);
    chk(o_noise_flag, 12'h000);
    @(posedge i_sys_clk) i_rx_interrupt_enable <= 1'b1;
    for (int k = 0; k < 3; k++) rx_word(9'($urandom), 0, -1, 1'b0);
    void'(exp_q.pop_back());
    @(negedge i_sys_clk);
    chk({o_overrun_flag, 11'(irq_cnt)}, 12'h803);
    sw_seq(1'b0);
    @(negedge i_sys_clk);
    chk(o_overrun_flag, 12'h000);
    sw_seq(1'b0);
    exp_q.push_back(11'h200);
    far.send_bits(24'h000000, 24, -1);
    repeat (32) @(posedge i_sys_clk);
    rx_word(9'($urandom), 0, -1, 1'b0);
    sw_seq(1'b0);
    sw_seq(1'b0);
    @(negedge i_sys_clk);
    chk({o_rx_data_available_flag, 11'(exp_q.size())}, 12'h000);
    @(posedge i_sys_clk);
    i_tx_write <= 1'b1;
    @(posedge i_sys_clk);
    i_tx_write <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(o_tx_idle_flag, 12'h001);
    sw_seq(1'b1);
    @(negedge i_sys_clk);
    chk({o_tx_idle_flag, o_tx_buffer_empty_flag}, 12'h000);
    wait_line(1'b0);
    wait_line(1'b1);
    @(negedge i_sys_clk);
    chk({12'(far.o_low_run)}, 12'h050);
    repeat (400) @(negedge i_sys_clk);
    chk({o_tx_idle_flag, 11'(txirq_cnt)}, 12'h801);
    @(posedge i_sys_clk);
    i_break_request_bit <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      wait_line(1'b0);
      wait_line(1'b1);
      @(negedge i_sys_clk);
      chk(12'(far.o_low_run), 12'h0e0);
    end
    @(posedge i_sys_clk);
    i_break_request_bit <= 1'b0;
    repeat (200) @(negedge i_sys_clk);
    chk({o_tx_idle_flag, o_serial_out_pin, 10'(txirq_cnt)}, 12'hc01);
    end_of_test();
  end
endmodule // test_uart_rx_break_tx
